// ### rtl/timer8_consts.svh
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// Register indices on the plain register port.
`define ADDR_COUNTER 3'h0
`define ADDR_COMPARE 3'h1
`define ADDR_CONTROL 3'h2
`define ADDR_FLAGS 3'h3
`define ADDR_MASK 3'h4
`define ADDR_ASYNC 3'h5

// Field positions in the control register.
`define CTL_FORCE 7
`define CTL_WAVE_HI 6
`define CTL_WAVE_LO 5
`define CTL_COM_HI 4
`define CTL_COM_LO 3
`define CTL_CS_HI 2
`define CTL_CS_LO 0

// Flag and mask bit positions, async select position.
`define BIT_COMPARE 1
`define BIT_OVERFLOW 0
`define BIT_ASYNC 0

// Counter extremes and reset values.
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define RESET_BYTE 8'h00

`endif

// ### rtl/timer8_pkg.sv
package timer8_pkg;

   typedef enum logic [1:0]
   {
      wave_normal = 2'b00,
      wave_phase_pwm = 2'b01,
      wave_ctc = 2'b10,
      wave_fast_pwm = 2'b11
   } wave_mode_t;

   typedef enum logic [1:0]
   {
      com_none = 2'b00,
      com_toggle = 2'b01,
      com_clear = 2'b10,
      com_set = 2'b11
   } com_mode_t;

endpackage

// ### rtl/timer8_async_compare_unit.sv
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "timer8_consts.svh"

module timer8_async_compare_unit #(
   parameter int PRESCALE_W = 10
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Register port.
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Crystal pins.
   input wire logic crystal_pin_in,
   output logic crystal_pin_out,
   // Interrupt requests and service acknowledges.
   input wire logic compare_irq_ack,
   input wire logic overflow_irq_ack,
   output logic compare_irq,
   output logic overflow_irq,
   // Waveform output.
   output logic compare_output
);

   if (PRESCALE_W < 10)
   begin
      $error("Prescaler must be at least ten bits wide.");
   end

   logic [7:0] counter_value;
   logic [7:0] compare_value;
   logic [7:0] compare_buffer;
   logic [1:0] wave_bits;
   logic [1:0] com_bits;
   logic [2:0] clock_select_field;
   logic async_clock_select;
   logic compare_match_flag;
   logic overflow_flag;
   logic compare_interrupt_enable;
   logic overflow_interrupt_enable;
   logic count_down;
   logic match_block;
   logic xtal_s1;
   logic xtal_s2;
   logic xtal_s3;
   logic [PRESCALE_W-1:0] prescale;
   logic [7:0] next_count;
   logic next_down;
   logic next_oc;

   timer8_pkg::wave_mode_t wave_mode;
   timer8_pkg::com_mode_t com_mode;
   assign wave_mode = timer8_pkg::wave_mode_t'(wave_bits);

   // Register decode.
   wire wr_counter = reg_write && (reg_addr == `ADDR_COUNTER);
   wire wr_compare = reg_write && (reg_addr == `ADDR_COMPARE);
   wire wr_control = reg_write && (reg_addr == `ADDR_CONTROL);
   wire wr_flags = reg_write && (reg_addr == `ADDR_FLAGS);
   wire wr_mask = reg_write && (reg_addr == `ADDR_MASK);
   wire wr_async = reg_write && (reg_addr == `ADDR_ASYNC);
   wire [1:0] com_now = wr_control ? reg_wdata[`CTL_COM_HI:`CTL_COM_LO] : com_bits;
   assign com_mode = timer8_pkg::com_mode_t'(com_now);

   wire pwm_mode = wave_bits[0];
   wire at_max = (counter_value == `COUNT_MAX);
   wire at_bottom = (counter_value == `COUNT_BOTTOM);

   // Timer clock: io clock cycles or crystal rising edges, divided down by the prescaler that the clock select field picks.
   wire xtal_edge = xtal_s2 && !xtal_s3;
   wire src_tick = async_clock_select ? xtal_edge : 1'b1;
   wire [9:0] prescale_mask =
      (clock_select_field == 3'h2) ? 10'h007 :
      (clock_select_field == 3'h3) ? 10'h01f :
      (clock_select_field == 3'h4) ? 10'h03f :
      (clock_select_field == 3'h5) ? 10'h07f :
      (clock_select_field == 3'h6) ? 10'h0ff :
      (clock_select_field == 3'h7) ? 10'h3ff : 10'h000;
   wire prescale_hit = ((prescale[9:0] & prescale_mask) == prescale_mask);
   wire timer_clock = (clock_select_field != 3'h0) && src_tick && prescale_hit;

   // Compare: a blocked tick after a counter write sees no match.
   wire equal_now = (counter_value == compare_value);
   wire eff_match = timer_clock && equal_now && !match_block;

   // Force only acts in the non-PWM modes.
   wire force_hit = wr_control && reg_wdata[`CTL_FORCE] && !reg_wdata[`CTL_WAVE_LO];

   // Overflow event by mode; top for PWM buffer update is maximum.
   wire ovf_event = timer_clock &&
      (pwm_mode && !wave_bits[1] ? (count_down && at_bottom) : at_max);
   wire top_tick = timer_clock && at_max && pwm_mode;

   wire cmp_clear = (wr_flags && reg_wdata[`BIT_COMPARE]) || compare_irq_ack;
   wire ovf_clear = (wr_flags && reg_wdata[`BIT_OVERFLOW]) || overflow_irq_ack;
   // Read multiplexer; compare reads the buffer while buffering.
   wire [7:0] ctl_read = {1'b0, wave_bits, com_bits, clock_select_field};
   wire [7:0] cmp_read = pwm_mode ? compare_buffer : compare_value;
   wire [7:0] read_mux =
      (reg_addr == `ADDR_COUNTER) ? counter_value :
      (reg_addr == `ADDR_COMPARE) ? cmp_read :
      (reg_addr == `ADDR_CONTROL) ? ctl_read :
      (reg_addr == `ADDR_FLAGS) ? {6'h00, compare_match_flag, overflow_flag} :
      (reg_addr == `ADDR_MASK) ?
         {6'h00, compare_interrupt_enable, overflow_interrupt_enable} :
      (reg_addr == `ADDR_ASYNC) ? {7'h00, async_clock_select} : 8'h00;

   assign compare_irq = compare_match_flag && compare_interrupt_enable;
   assign overflow_irq = overflow_flag && overflow_interrupt_enable;
   // Counter sequencing.
   always_comb
   begin
      next_count = counter_value;
      next_down = count_down;
      if (timer_clock)
      begin
         unique case (wave_mode)
            timer8_pkg::wave_normal:
            begin
               next_count = counter_value + 8'h01;
            end
            timer8_pkg::wave_ctc:
            begin
               next_count = eff_match ? `COUNT_BOTTOM : counter_value + 8'h01;
            end
            timer8_pkg::wave_fast_pwm:
            begin
               next_count = at_max ? `COUNT_BOTTOM : counter_value + 8'h01;
            end
            timer8_pkg::wave_phase_pwm:
            begin
               if (count_down ? at_bottom : at_max)
               begin
                  next_down = !count_down;
                  next_count = count_down ? counter_value + 8'h01 : counter_value - 8'h01;
               end
               else
               begin
                  next_count = count_down ? counter_value - 8'h01 : counter_value + 8'h01;
               end
            end
         endcase
      end
      if (wr_counter)
      begin
         next_count = reg_wdata;
      end
   end

   // Output state; mode bits act at once for force and non-PWM matches, and mode zero does nothing.
   always_comb
   begin
      next_oc = compare_output;
      if (force_hit || (eff_match && !pwm_mode))
      begin
         unique case (com_mode)
            timer8_pkg::com_none: next_oc = compare_output;
            timer8_pkg::com_toggle: next_oc = !compare_output;
            timer8_pkg::com_clear: next_oc = 1'b0;
            timer8_pkg::com_set: next_oc = 1'b1;
         endcase
      end
      else if (eff_match && pwm_mode && com_bits[1])
      begin
         next_oc = com_bits[0] ^ (wave_bits[1] ? 1'b0 : count_down);
      end
      else if (top_tick && wave_bits[1] && com_bits[1])
      begin
         next_oc = !com_bits[0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         xtal_s1 <= 1'b0;
         xtal_s2 <= 1'b0;
         xtal_s3 <= 1'b0;
         crystal_pin_out <= 1'b1;
      end
      else
      begin
         xtal_s1 <= crystal_pin_in;
         xtal_s2 <= xtal_s1;
         xtal_s3 <= xtal_s2;
         crystal_pin_out <= !xtal_s2;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         prescale <= '0;
      end
      else if (clock_select_field == 3'h0 || src_tick)
      begin
         prescale <= (clock_select_field == 3'h0) ? '0 : prescale + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         counter_value <= `RESET_BYTE;
         count_down <= 1'b0;
         match_block <= 1'b0;
         compare_output <= 1'b0;
      end
      else
      begin
         counter_value <= next_count;
         count_down <= next_down;
         match_block <= wr_counter || (match_block && !timer_clock);
         compare_output <= next_oc;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         compare_value <= `RESET_BYTE;
         compare_buffer <= `RESET_BYTE;
      end
      else
      begin
         if (wr_compare)
         begin
            compare_buffer <= reg_wdata;
         end
         if (wr_compare && !pwm_mode)
         begin
            compare_value <= reg_wdata;
         end
         else if (top_tick)
         begin
            compare_value <= compare_buffer;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         wave_bits <= 2'b00;
         com_bits <= 2'b00;
         clock_select_field <= 3'h0;
         async_clock_select <= 1'b0;
         compare_interrupt_enable <= 1'b0;
         overflow_interrupt_enable <= 1'b0;
      end
      else
      begin
         if (wr_control)
         begin
            wave_bits <= reg_wdata[`CTL_WAVE_HI:`CTL_WAVE_LO];
            com_bits <= reg_wdata[`CTL_COM_HI:`CTL_COM_LO];
            clock_select_field <= reg_wdata[`CTL_CS_HI:`CTL_CS_LO];
         end
         if (wr_async)
         begin
            async_clock_select <= reg_wdata[`BIT_ASYNC];
         end
         if (wr_mask)
         begin
            compare_interrupt_enable <= reg_wdata[`BIT_COMPARE];
            overflow_interrupt_enable <= reg_wdata[`BIT_OVERFLOW];
         end
      end
   end

   // Flags: a setting event wins over a clear in the same cycle.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         compare_match_flag <= 1'b0;
         overflow_flag <= 1'b0;
         reg_rdata <= 8'h00;
      end
      else
      begin
         compare_match_flag <= eff_match || (compare_match_flag && !cmp_clear);
         overflow_flag <= ovf_event || (overflow_flag && !ovf_clear);
         reg_rdata <= reg_read ? read_mux : 8'h00;
      end
   end

   a_write_wins: assert property (@(posedge ref_clk) disable iff (reset)
      wr_counter |=> counter_value == $past(reg_wdata))
      else $error("Counter write did not land.");

   a_stop_holds: assert property (@(posedge ref_clk) disable iff (reset)
      (clock_select_field == 3'h0 && !wr_counter) |=> $stable(counter_value))
      else $error("Stopped counter moved.");

   a_flag_after_match: assert property (@(posedge ref_clk) disable iff (reset)
      (timer_clock && equal_now && !match_block) |=> compare_match_flag)
      else $error("Compare flag not set after match.");

   a_block_match: assert property (@(posedge ref_clk) disable iff (reset)
      (wr_counter ##1 (timer_clock && !compare_match_flag)) |=> !compare_match_flag)
      else $error("Match not blocked after counter write.");

   a_normal_wrap: assert property (@(posedge ref_clk) disable iff (reset)
      (timer_clock && wave_bits == 2'b00 && at_max && !wr_counter)
      |=> (counter_value == 8'h00) && overflow_flag)
      else $error("Normal mode wrap wrong.");

   a_ctc_clear: assert property (@(posedge ref_clk) disable iff (reset)
      (wave_bits == 2'b10 && eff_match && !wr_counter) |=> counter_value == 8'h00)
      else $error("Clear on match failed.");

   a_fast_top: assert property (@(posedge ref_clk) disable iff (reset)
      (timer_clock && wave_bits == 2'b11 && at_max && !wr_counter) |=> at_bottom)
      else $error("Fast mode did not restart.");

   a_com_none: assert property (@(posedge ref_clk) disable iff (reset)
      (com_bits == 2'b00 && !wr_control) |=> $stable(compare_output))
      else $error("Output moved with output mode zero.");

   a_irq_gate: assert property (@(posedge ref_clk) disable iff (reset)
      (eff_match && compare_interrupt_enable && !wr_mask) |=> compare_irq)
      else $error("Compare request missing.");

   c_ctc_match: cover property (@(posedge ref_clk) disable iff (reset)
      wave_bits == 2'b10 && eff_match);
   c_phase_turn: cover property (@(posedge ref_clk) disable iff (reset)
      wave_bits == 2'b01 && timer_clock && at_max);
   c_force: cover property (@(posedge ref_clk) disable iff (reset)
      force_hit && com_bits == 2'b01);
   c_crystal: cover property (@(posedge ref_clk) disable iff (reset)
      async_clock_select && timer_clock);

endmodule

// ### tb/timer8_async_compare_unit_test.sv
`timescale 1ns/100ps
module timer8_async_compare_unit_test;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic crystal_pin_in = 1'b0;
   logic compare_irq_ack = 1'b0;
   logic overflow_irq_ack = 1'b0;
   logic compare_irq;
   logic overflow_irq;
   logic compare_output;
   logic crystal_pin_out;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [7:0] force_ctl [5] = '{8'h98, 8'h80, 8'h90, 8'h88, 8'h88};
   logic force_out [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

   timer8_async_compare_unit DUT
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .crystal_pin_in(crystal_pin_in),
      .crystal_pin_out(crystal_pin_out),
      .compare_irq_ack(compare_irq_ack),
      .overflow_irq_ack(overflow_irq_ack),
      .compare_irq(compare_irq),
      .overflow_irq(overflow_irq),
      .compare_output(compare_output)
   );

   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end

   // Ends a hung run after a bounded number of cycles.
   always @(posedge ref_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 8000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
      rd(a, d);
      chk(name, exp, d);
   endtask

   // Runs the timer for n+2 cycles, then stops it but keeps the waveform mode.
   task automatic run(input logic [7:0] ctl, input int n);
      wr(3'h2, ctl);
      repeat (n) @(posedge ref_clk);
      wr(3'h2, ctl & 8'h60);
   endtask

   task automatic pins(input string name, input logic [7:0] exp);
      @(posedge ref_clk);
      #1 chk(name, exp, {5'h00, compare_irq, overflow_irq, compare_output});
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++)
         rchk("reset_value", i[2:0], 8'h00);
      pins("reset_outputs", 8'h00);
      $display("test reset finished");

      wr(3'h0, 8'h5a);
      repeat (10) @(posedge ref_clk);
      rchk("stopped_count", 3'h0, 8'h5a);
      $display("test stopped finished");

      wr(3'h4, 8'h03);
      wr(3'h1, 8'h80);
      wr(3'h0, 8'hfe);
      run(8'h01, 8);
      rchk("overflow_flag", 3'h3, 8'h01);
      pins("overflow_irq", 8'h02);
      wr(3'h3, 8'h01);
      rchk("overflow_clear", 3'h3, 8'h00);
      $display("test overflow finished");

      wr(3'h1, 8'h05);
      wr(3'h0, 8'h05);
      run(8'h01, 20);
      rchk("blocked_match", 3'h3, 8'h00);
      wr(3'h0, 8'h00);
      run(8'h01, 20);
      rchk("compare_flag", 3'h3, 8'h02);
      pins("compare_irq", 8'h04);
      @(posedge ref_clk);
      compare_irq_ack <= 1'b1;
      @(posedge ref_clk);
      compare_irq_ack <= 1'b0;
      rchk("compare_serviced", 3'h3, 8'h00);
      $display("test compare finished");

      wr(3'h1, 8'h03);
      wr(3'h0, 8'h00);
      run(8'h41, 40);
      rd(3'h0, d);
      chk("ctc_top", 8'h01, {7'h00, d <= 8'h03});
      rchk("ctc_flags", 3'h3, 8'h02);
      wr(3'h3, 8'h03);
      $display("test ctc finished");

      wr(3'h0, 8'h77);
      for (int i = 0; i < 5; i++)
      begin
         wr(3'h2, force_ctl[i]);
         pins("forced_output", {7'h00, force_out[i]});
      end
      rchk("force_no_flag", 3'h3, 8'h00);
      rchk("force_no_count", 3'h0, 8'h77);
      wr(3'h2, 8'h98);
      wr(3'h2, 8'h40);
      pins("mode_change_ctc", 8'h01);
      wr(3'h2, 8'h60);
      wr(3'h2, 8'hf0);
      pins("pwm_force_ignored", 8'h01);
      $display("test force finished");

      wr(3'h1, 8'h40);
      rchk("buffer_read", 3'h1, 8'h40);
      wr(3'h2, 8'h00);
      rchk("active_kept", 3'h1, 8'h03);
      wr(3'h2, 8'h60);
      wr(3'h0, 8'h00);
      run(8'h71, 320);
      rchk("fast_flags", 3'h3, 8'h03);
      pins("fast_pwm_output", 8'h06);
      wr(3'h2, 8'h00);
      rchk("active_loaded", 3'h1, 8'h40);
      $display("test fast pwm finished");

      wr(3'h3, 8'h03);
      wr(3'h0, 8'h00);
      run(8'h21, 300);
      rd(3'h3, d);
      chk("phase_no_ovf", 8'h00, {7'h00, d[0]});
      run(8'h21, 300);
      rd(3'h3, d);
      chk("phase_ovf", 8'h01, {7'h00, d[0]});
      @(posedge ref_clk);
      overflow_irq_ack <= 1'b1;
      @(posedge ref_clk);
      overflow_irq_ack <= 1'b0;
      pins("overflow_serviced", 8'h04);
      $display("test phase pwm finished");

      wr(3'h2, 8'h00);
      wr(3'h0, 8'h00);
      run(8'h02, 30);
      rchk("prescaled_count", 3'h0, 8'h04);
      wr(3'h0, 8'h00);
      wr(3'h5, 8'h01);
      rchk("async_select", 3'h5, 8'h01);
      wr(3'h2, 8'h01);
      repeat (20) @(posedge ref_clk);
      rchk("async_idle", 3'h0, 8'h00);
      repeat (5)
      begin
         repeat (4) @(posedge ref_clk);
         crystal_pin_in <= 1'b1;
         repeat (4) @(posedge ref_clk);
         crystal_pin_in <= 1'b0;
         #1 chk("crystal_out_inverse_high", 8'h00, {7'h00, crystal_pin_out});
      end
      repeat (10) @(posedge ref_clk);
      #1 chk("crystal_out_inverse_low", 8'h01, {7'h00, crystal_pin_out});
      wr(3'h2, 8'h00);
      rchk("async_count", 3'h0, 8'h05);
      $display("test async finished");
      tally_and_finish();
   end
endmodule
